// File: verilog/pocf_bank.sv
// control field bank for reference-oscillator output and pll settings
// assumes 50 MHz clk, synchronous reset, plain register port with read data
// one cycle after the read strobe
//
// Operation
// RL1: oscillator output power bit, reset off
// RL2: oscillator output format bit, reset differential
// RL3: offset reaches detector only when enabled
// RL4: five-bit offset code, 0.9 degree steps
// RL5: software keeps offset zero unless jitter
// RL6: pump code, 200 uA times code plus one
// RL7: amplitude decode same for both formats
// RL8: fields read back, reset to defaults
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
module pocf_bank #(
  parameter int CODE_WIDTH = 5
) (
  input  wire logic                            clk,
  input  wire logic                            rstn,
  input  wire logic [7:0]                      regAddr,
  input  wire logic [7:0]                      regWrData,
  input  wire logic                            regWr,
  input  wire logic                            regRd,
  output logic      [7:0]                      regRdData,
  output logic                                 oscOutPowerOn,
  output logic                                 oscOutFormat,
  output logic      [1:0]                      oscOutAmplitude,
  output logic      [1:0]                      oscOutLevel,
  output logic      [CODE_WIDTH-1:0]           detectorOffset,
  output logic                                 phaseOffsetEnable,
  output logic      [CODE_WIDTH-1:0]           synthPumpCurrentCode,
  output logic      [CODE_WIDTH:0]             synthPumpSteps
);

  // ==========================================================
  // local constants
  localparam int         REG_W         = 8;
  localparam int         POS_LEVEL_LSB = 0;
  localparam logic [7:0] RD_IDLE       = 8'h00;

  // ==========================================================
  // elaboration checks
  if (CODE_WIDTH != pocf_pkg::CODE_W)
  begin : gWidthCheck
    $error("code width must match the stored field width");
  end

  if (pocf_pkg::POS_OFS_LSB + CODE_WIDTH > pocf_pkg::POS_OFS_EN)
  begin : gOscLayoutCheck
    $error("offset code overlaps the offset enable bit");
  end

  if (pocf_pkg::POS_PUMP_LSB + CODE_WIDTH > pocf_pkg::POS_AMP_LSB)
  begin : gPumpLayoutCheck
    $error("pump code overlaps the amplitude field");
  end

  if (pocf_pkg::POS_AMP_LSB + pocf_pkg::AMP_W > REG_W)
  begin : gAmpLayoutCheck
    $error("amplitude field runs past the register word");
  end

  if (pocf_pkg::POS_POWER >= REG_W || pocf_pkg::POS_FORMAT >= REG_W ||
      pocf_pkg::POS_OFS_EN >= REG_W)
  begin : gBitLayoutCheck
    $error("control bits lie outside the register word");
  end

  if (pocf_pkg::POS_POWER == pocf_pkg::POS_FORMAT ||
      pocf_pkg::POS_POWER == pocf_pkg::POS_OFS_EN ||
      pocf_pkg::POS_FORMAT == pocf_pkg::POS_OFS_EN)
  begin : gBitDistinctCheck
    $error("control bits share a position");
  end

  if ($bits(oscOutAmplitude) != pocf_pkg::AMP_W)
  begin : gAmpWidthCheck
    $error("amplitude port width must match the stored field width");
  end

  if ($bits(regWrData) != REG_W || $bits(regRdData) != REG_W)
  begin : gBusWidthCheck
    $error("register port width must match the register word");
  end

  if (pocf_pkg::RST_FIELDS.format != pocf_pkg::RST_FORMAT)
  begin : gResetFormatCheck
    $error("stored and output format defaults disagree");
  end

  if (pocf_pkg::ADDR_OSC_CTRL == pocf_pkg::ADDR_PUMP_CTRL ||
      pocf_pkg::ADDR_OSC_CTRL == pocf_pkg::ADDR_STATUS ||
      pocf_pkg::ADDR_PUMP_CTRL == pocf_pkg::ADDR_STATUS)
  begin : gAddrDistinctCheck
    $error("register addresses must be distinct");
  end

  // ==========================================================
  // address decode, shared by the write and read paths
  function automatic logic hitAddr(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  wire logic hitOsc    = hitAddr(regAddr, pocf_pkg::ADDR_OSC_CTRL);
  wire logic hitPump   = hitAddr(regAddr, pocf_pkg::ADDR_PUMP_CTRL);
  wire logic hitStatus = hitAddr(regAddr, pocf_pkg::ADDR_STATUS);
  wire logic wrOsc     = regWr && hitOsc;
  wire logic wrPump    = regWr && hitPump;

  // ==========================================================
  // field storage
  pocf_pkg::pocf_fields_t fields;

  pocf_field_store uStore (
    .clk    (clk),
    .rstn   (rstn),
    .wrOsc  (wrOsc),
    .wrPump (wrPump),
    .wrData (regWrData),
    .fields (fields)
  );

  // ==========================================================
  // amplitude decode, independent of output format
  function automatic pocf_pkg::pocf_amp_t ampLevel(input logic [1:0] code);
    pocf_pkg::pocf_amp_t lvl;
    lvl = pocf_pkg::POCF_AMP_LOW;
    case (code)
      2'h0:    lvl = pocf_pkg::POCF_AMP_LOW;
      2'h1:    lvl = pocf_pkg::POCF_AMP_MID;
      2'h2:    lvl = pocf_pkg::POCF_AMP_MID;
      2'h3:    lvl = pocf_pkg::POCF_AMP_HIGH;
      default: lvl = pocf_pkg::POCF_AMP_LOW;
    endcase
    return lvl;
  endfunction

  wire pocf_pkg::pocf_amp_t ampNow = ampLevel(fields.amplitude); // [RL7]

  // ==========================================================
  // detector offset, zero unless the enable bit is set
  function automatic logic [CODE_WIDTH-1:0] gateOffset(
    input logic                  enable,
    input logic [CODE_WIDTH-1:0] code
  );
    logic [CODE_WIDTH-1:0] applied;
    applied = '0;
    if (enable)
      applied = code;
    return applied;
  endfunction

  wire logic [CODE_WIDTH-1:0] offsetNow =
    gateOffset(fields.offsetEnable, fields.offsetCode); // [RL3] [RL4]

  // ==========================================================
  // pump current in 200 uA steps: code plus one
  function automatic logic [CODE_WIDTH:0] pumpSteps(input logic [CODE_WIDTH-1:0] code);
    return {1'b0, code} + {{CODE_WIDTH{1'b0}}, 1'b1};
  endfunction

  wire logic [CODE_WIDTH:0] pumpStepsNow = pumpSteps(fields.pumpCode); // [RL6]

  // ==========================================================
  // read-back words
  // fields sit at named positions; spare bits read 0
  function automatic logic [7:0] packOscWord(input pocf_pkg::pocf_fields_t f);
    logic [7:0] w;
    w = '0;
    w[pocf_pkg::POS_POWER]  = f.powerOn;
    w[pocf_pkg::POS_FORMAT] = f.format;
    w[pocf_pkg::POS_OFS_EN] = f.offsetEnable;
    w[pocf_pkg::POS_OFS_LSB +: pocf_pkg::CODE_W] = f.offsetCode;
    return w;
  endfunction

  function automatic logic [7:0] packPumpWord(input pocf_pkg::pocf_fields_t f);
    logic [7:0] w;
    w = '0;
    w[pocf_pkg::POS_AMP_LSB +: pocf_pkg::AMP_W]   = f.amplitude;
    w[pocf_pkg::POS_PUMP_LSB +: pocf_pkg::CODE_W] = f.pumpCode;
    return w;
  endfunction

  function automatic logic [7:0] packStatusWord(input pocf_pkg::pocf_amp_t lvl);
    logic [7:0] w;
    w = '0;
    w[POS_LEVEL_LSB +: $bits(pocf_pkg::pocf_amp_t)] = lvl;
    return w;
  endfunction

  wire logic [7:0] oscWord    = packOscWord(fields); // [RL1] [RL2] [RL8]
  wire logic [7:0] pumpWord   = packPumpWord(fields); // [RL8]
  wire logic [7:0] statusWord = packStatusWord(ampNow);

  wire logic [7:0] rdSelect =
    hitOsc    ? oscWord    :
    hitPump   ? pumpWord   :
    hitStatus ? statusWord : RD_IDLE;

  // ==========================================================
  // read data: one cycle after the strobe, idle value otherwise
  // idle zero keeps a stray sample from showing a stale word
  wire logic [7:0] next_regRdData = regRd ? rdSelect : RD_IDLE;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      regRdData <= RD_IDLE;
    else
      regRdData <= next_regRdData; // [RL8]
  end

  // ==========================================================
  // oscillator output power
  wire logic next_oscOutPowerOn = fields.powerOn;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      oscOutPowerOn <= pocf_pkg::RST_POWER;
    else
      oscOutPowerOn <= next_oscOutPowerOn; // [RL1]
  end

  // ==========================================================
  // oscillator output format
  wire logic next_oscOutFormat = fields.format;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      oscOutFormat <= pocf_pkg::RST_FORMAT;
    else
      oscOutFormat <= next_oscOutFormat; // [RL2]
  end

  // ==========================================================
  // raw amplitude field
  wire logic [1:0] next_oscOutAmplitude = fields.amplitude;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      oscOutAmplitude <= pocf_pkg::RST_AMP;
    else
      oscOutAmplitude <= next_oscOutAmplitude; // [RL8]
  end

  // ==========================================================
  // decoded amplitude level
  // format is not an input of the decode on purpose
  wire logic [1:0] next_oscOutLevel = ampNow;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      oscOutLevel <= ampLevel(pocf_pkg::RST_AMP);
    else
      oscOutLevel <= next_oscOutLevel; // [RL7]
  end

  // ==========================================================
  // offset applied at the detector
  // gated before the flop so a disabled code never reaches the pin
  wire logic [CODE_WIDTH-1:0] next_detectorOffset = offsetNow;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      detectorOffset <= gateOffset(pocf_pkg::RST_OFS_EN, pocf_pkg::RST_OFFSET);
    else
      detectorOffset <= next_detectorOffset; // [RL3]
  end

  // ==========================================================
  // offset enable bit
  wire logic next_phaseOffsetEnable = fields.offsetEnable;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      phaseOffsetEnable <= pocf_pkg::RST_OFS_EN;
    else
      phaseOffsetEnable <= next_phaseOffsetEnable; // [RL3]
  end

  // ==========================================================
  // synthesizer pump code
  wire logic [CODE_WIDTH-1:0] next_synthPumpCurrentCode = fields.pumpCode;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      synthPumpCurrentCode <= pocf_pkg::RST_PUMP;
    else
      synthPumpCurrentCode <= next_synthPumpCurrentCode; // [RL6]
  end

  // ==========================================================
  // pump current in unit steps
  // one bit wider so the top code does not wrap to zero
  wire logic [CODE_WIDTH:0] next_synthPumpSteps = pumpStepsNow;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      synthPumpSteps <= pumpSteps(pocf_pkg::RST_PUMP);
    else
      synthPumpSteps <= next_synthPumpSteps; // [RL6]
  end

endmodule

// File: include/pocf_pkg.sv
// package for the oscillator-output and pll control field bank
// assumes a single 50 MHz clock and a plain address/strobe register port
package pocf_pkg;

  // ==========================================================
  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] ADDR_OSC_CTRL  = 8'h11;
  localparam logic [7:0] ADDR_PUMP_CTRL = 8'h12;
  localparam logic [7:0] ADDR_STATUS    = 8'h13;

  // ==========================================================
  // field positions
  localparam int POS_POWER    = 7;
  localparam int POS_FORMAT   = 6;
  localparam int POS_OFS_EN   = 5;
  localparam int POS_OFS_LSB  = 0;
  localparam int POS_AMP_LSB  = 5;
  localparam int POS_PUMP_LSB = 0;
  localparam int CODE_W       = 5;
  localparam int AMP_W        = 2;

  // ==========================================================
  // reset values
  localparam logic              RST_POWER  = 1'h0;
  localparam logic              RST_FORMAT = 1'h0;
  localparam logic              RST_OFS_EN = 1'h0;
  localparam logic [CODE_W-1:0] RST_OFFSET = 5'h00;
  localparam logic [CODE_W-1:0] RST_PUMP   = 5'h18;
  localparam logic [AMP_W-1:0]  RST_AMP    = 2'h0;

  // ==========================================================
  // analog scale figures
  localparam int PUMP_STEP_UA   = 200;
  localparam int OFS_STEP_MDEG  = 900;
  localparam int AMP_LOW_MV     = 250;
  localparam int AMP_MID_MV     = 500;
  localparam int AMP_HIGH_MV    = 750;

  typedef enum logic { POCF_FMT_LVDS, POCF_FMT_ECL } pocf_format_t;

  // amplitude level after decode
  typedef enum logic [1:0] { POCF_AMP_LOW, POCF_AMP_MID, POCF_AMP_HIGH } pocf_amp_t;

  typedef struct packed {
    logic              powerOn;
    pocf_format_t      format;
    logic              offsetEnable;
    logic [CODE_W-1:0] offsetCode;
    logic [AMP_W-1:0]  amplitude;
    logic [CODE_W-1:0] pumpCode;
  } pocf_fields_t;

  localparam pocf_fields_t RST_FIELDS = '{
    powerOn:      RST_POWER,
    format:       POCF_FMT_LVDS,
    offsetEnable: RST_OFS_EN,
    offsetCode:   RST_OFFSET,
    amplitude:    RST_AMP,
    pumpCode:     RST_PUMP
  };

endpackage

// File: verilog/pocf_field_store.sv
// field store: holds the control fields, written by byte, reset to defaults
// assumes synchronous active-low reset and one write strobe per cycle
module pocf_field_store (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  wrOsc,
  input  wire logic                  wrPump,
  input  wire logic [7:0]            wrData,
  output pocf_pkg::pocf_fields_t     fields
);

  // ==========================================================
  // next value
  pocf_pkg::pocf_fields_t next_fields;

  always_comb
  begin
    next_fields = fields;
    if (wrOsc)
    begin
      next_fields.powerOn      = wrData[pocf_pkg::POS_POWER];
      next_fields.format       = pocf_pkg::pocf_format_t'(wrData[pocf_pkg::POS_FORMAT]);
      next_fields.offsetEnable = wrData[pocf_pkg::POS_OFS_EN];
      next_fields.offsetCode   =
        wrData[pocf_pkg::POS_OFS_LSB +: pocf_pkg::CODE_W];
    end
    if (wrPump)
    begin
      next_fields.amplitude = wrData[pocf_pkg::POS_AMP_LSB +: pocf_pkg::AMP_W];
      next_fields.pumpCode  = wrData[pocf_pkg::POS_PUMP_LSB +: pocf_pkg::CODE_W];
    end
  end

  // ==========================================================
  // storage
  always_ff @(posedge clk)
  begin
    if (!rstn)
      fields <= pocf_pkg::RST_FIELDS; // [RL8]
    else
      fields <= next_fields; // [RL8]
  end

endmodule

// File: bench/pocf_bank_checker.sv
// checker: port-level properties of the control field bank
// assumes it is bound to pocf_bank; one clock, synchronous active-low reset
module pocf_bank_checker #(
  parameter int CODE_WIDTH = 5
) (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire logic [7:0]            regAddr,
  input wire logic [7:0]            regWrData,
  input wire logic                  regWr,
  input wire logic                  regRd,
  input wire logic [7:0]            regRdData,
  input wire logic                  oscOutPowerOn,
  input wire logic                  oscOutFormat,
  input wire logic [1:0]            oscOutAmplitude,
  input wire logic [1:0]            oscOutLevel,
  input wire logic [CODE_WIDTH-1:0] detectorOffset,
  input wire logic                  phaseOffsetEnable,
  input wire logic [CODE_WIDTH-1:0] synthPumpCurrentCode,
  input wire logic [CODE_WIDTH:0]   synthPumpSteps
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // decode helpers
  wire logic wOsc   = regWr && regAddr == pocf_pkg::ADDR_OSC_CTRL;
  wire logic wPump  = regWr && regAddr == pocf_pkg::ADDR_PUMP_CTRL;
  wire logic mapped = regAddr inside
    {pocf_pkg::ADDR_OSC_CTRL, pocf_pkg::ADDR_PUMP_CTRL, pocf_pkg::ADDR_STATUS};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_pwr_format: assert property (
    $past(wOsc, 2) |-> {oscOutPowerOn, oscOutFormat} == $past(regWrData[7:6], 2)) else $error("osc bits");
  a_offset_load: assert property (
    $past(wOsc, 2) && $past(regWrData[5], 2) |-> detectorOffset == $past(regWrData[4:0], 2))
    else $error("offset code");
  a_offset_gate: assert property (
    !phaseOffsetEnable |-> detectorOffset == '0) else $error("offset while disabled");
  a_pump_load: assert property (
    $past(wPump, 2) |-> synthPumpCurrentCode == $past(regWrData[4:0], 2)) else $error("pump code");
  a_pump_steps: assert property (
    synthPumpSteps == {1'b0, synthPumpCurrentCode} + 1'b1) else $error("pump steps");
  a_amp_decode: assert property (
    oscOutLevel == (oscOutAmplitude == 2'h0 ? 2'h0 : oscOutAmplitude == 2'h3 ? 2'h2 : 2'h1))
    else $error("amplitude decode");
  a_reset_vals: assert property (
    !$past(rstn) |-> !oscOutPowerOn && synthPumpCurrentCode == pocf_pkg::RST_PUMP && !oscOutLevel)
    else $error("reset defaults");
  a_unmapped_rd: assert property (
    $past(regRd) && !$past(mapped) |-> regRdData == 8'h00) else $error("unmapped read");
  c_osc_write: cover property (wOsc && regWrData[5]);
  c_pump_write: cover property (wPump);
  c_status_rd: cover property (regRd && regAddr == pocf_pkg::ADDR_STATUS);
endmodule

// File: bench/pocf_bank_tb.sv
// testbench: directed scenarios for the control field bank
// assumes pocf_pkg and pocf_bank are compiled first; 50 MHz clock
module pocf_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
  logic [7:0] regRdData;
  logic       oscOutPowerOn, oscOutFormat, phaseOffsetEnable;
  logic [1:0] oscOutAmplitude, oscOutLevel;
  logic [4:0] detectorOffset, synthPumpCurrentCode;
  logic [5:0] synthPumpSteps;
  int         failures = 0, compares = 0;
  always #10 clk = ~clk;
  pocf_bank #(.CODE_WIDTH(5)) i_pocf_bank (.clk, .rstn, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .oscOutPowerOn, .oscOutFormat, .oscOutAmplitude, .oscOutLevel, .detectorOffset,
    .phaseOffsetEnable, .synthPumpCurrentCode, .synthPumpSteps);
  task end_sim;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  task do_reset;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1 chk({oscOutPowerOn, oscOutFormat, phaseOffsetEnable, detectorOffset}, 8'h00);
    chk({1'b0, oscOutAmplitude, synthPumpCurrentCode}, 8'h18);
    chk({2'h0, synthPumpSteps}, 8'h19);
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h18);
  endtask
  task t_osc;
    wr(8'h11, 8'hE5);
    chk({oscOutPowerOn, oscOutFormat, phaseOffsetEnable, detectorOffset}, 8'hE5);
    wr(8'h11, 8'h1F);
    chk({oscOutPowerOn, oscOutFormat, phaseOffsetEnable, detectorOffset}, 8'h00);
    rd(8'h11, 8'h1F);
    @(posedge clk);
    #1 chk(regRdData, 8'h00);
    wr(8'h11, 8'h3F);
    chk({3'h1, detectorOffset}, 8'h3F);
    wr(8'h11, 8'hA0);
    chk({oscOutPowerOn, oscOutFormat, phaseOffsetEnable, detectorOffset}, 8'hA0);
  endtask
  task t_pump;
    logic [7:0] d [4];
    logic [7:0] lv [4];
    d = '{8'h00, 8'h2A, 8'h55, 8'h7F};
    lv = '{8'h00, 8'h01, 8'h01, 8'h02};
    for (int f = 0; f < 2; f++)
    begin
      wr(8'h11, f ? 8'h40 : 8'h00);
      chk({7'h0, oscOutFormat}, f[7:0]);
      for (int i = 0; i < 4; i++)
      begin
        wr(8'h12, d[i]);
        chk({2'h0, synthPumpSteps}, {3'h0, d[i][4:0]} + 8'h01);
        chk({1'b0, oscOutAmplitude, synthPumpCurrentCode}, d[i]);
        chk({6'h0, oscOutLevel}, lv[i]);
        rd(8'h12, d[i]);
        rd(8'h13, lv[i]);
      end
    end
  endtask
  initial
  begin
    do_reset;
    t_osc;
    t_pump;
    wr(8'h10, 8'hFF);
    wr(8'h13, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h40);
    rd(8'h13, 8'h02);
    do_reset;
    end_sim;
  end
  // watchdog
  initial
  begin
    #40000;
    failures++;
    end_sim;
  end
endmodule
bind pocf_bank pocf_bank_checker #(.CODE_WIDTH(CODE_WIDTH)) i_pocf_bank_checker (.clk, .rstn,
  .regAddr, .regWrData, .regWr, .regRd, .regRdData, .oscOutPowerOn, .oscOutFormat,
  .oscOutAmplitude, .oscOutLevel, .detectorOffset, .phaseOffsetEnable, .synthPumpCurrentCode,
  .synthPumpSteps);
